// ==== verilog/pdc_predriver_ctrl.sv ====
// Serial/parallel control and fault reporting of a four-channel low-side predriver.
// Assumes all pin inputs are asynchronous; serial clock is sampled, not used as a clock.
`timescale 1ns/100ps

module pdc_predriver_ctrl #(
	parameter logic [pdc_pkg::RETRY_W-1:0] RETRY_PERIOD_CYC = pdc_pkg::RETRY_PERIOD_CYC
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic serial_in,
	input wire logic ext_reset_n,
	input wire logic battery_fault,
	input wire logic retry_mode,
	input wire logic [pdc_pkg::NUM_CH-1:0] parallel_gate_cmd,
	input wire logic [pdc_pkg::NUM_CH-1:0] drain_sense_in,
	output logic [pdc_pkg::NUM_CH-1:0] gate_drive_out,
	output logic serial_out,
	output logic serial_out_oe,
	output logic fault_flag_n,
	output logic fault_flag_n_oe
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	pdc_pkg::pdc_state_s st;
	pdc_pkg::pdc_state_s next_st;
	pdc_pkg::pdc_pins_s pins;

	assign pins.cs_n = cs_n;
	assign pins.sclk = sclk;
	assign pins.serial_in = serial_in;
	assign pins.ext_reset_n = ext_reset_n;
	assign pins.battery_fault = battery_fault;
	assign pins.retry_mode = retry_mode;
	assign pins.parallel_gate_cmd = parallel_gate_cmd;
	assign pins.drain_sense_in = drain_sense_in;

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		logic cs_fall;
		logic cs_rise;
		logic sclk_rise;
		logic sclk_fall;
		logic batt;
		logic rmode;
		logic cmd;
		logic drain;
		logic mask_done;
		logic in_pulse;
		logic short_set;
		logic open_set;
		logic short_clr;
		logic gate_n;
		logic fault_event;
		logic fault_pending;
		logic [pdc_pkg::NUM_CH-1:0] fault_word;
		cs_fall = 1'b0;
		cs_rise = 1'b0;
		sclk_rise = 1'b0;
		sclk_fall = 1'b0;
		batt = 1'b0;
		rmode = 1'b0;
		cmd = 1'b0;
		drain = 1'b0;
		mask_done = 1'b0;
		in_pulse = 1'b0;
		short_set = 1'b0;
		open_set = 1'b0;
		short_clr = 1'b0;
		gate_n = 1'b0;
		fault_event = 1'b0;
		fault_pending = 1'b0;
		fault_word = '0;

		next_st = st;
		next_st.sync1 = pins;
		next_st.sync2 = st.sync1;
		next_st.sync3 = st.sync2;

		cs_fall = st.sync3.cs_n & ~st.sync2.cs_n;
		cs_rise = ~st.sync3.cs_n & st.sync2.cs_n;
		sclk_rise = ~st.sync3.sclk & st.sync2.sclk;
		sclk_fall = st.sync3.sclk & ~st.sync2.sclk;
		batt = st.sync2.battery_fault;
		rmode = st.sync2.retry_mode;

		// ----------------------------------------
		// Channels
		// ----------------------------------------
		for (int i = 0; i < pdc_pkg::NUM_CH; i++) begin
			cmd = st.ctrl[i] | st.sync2.parallel_gate_cmd[i];
			drain = st.sync2.drain_sense_in[i];
			mask_done = (st.chan[i].mask == '0);
			next_st.chan[i].cmd_prev = cmd;

			// Retry timer runs only while a short is latched
			in_pulse = (st.chan[i].retry >= RETRY_PERIOD_CYC - pdc_pkg::RETRY_PULSE_CYC);
			if (st.chan[i].short_lat & rmode) begin
				if (st.chan[i].retry == RETRY_PERIOD_CYC - 1'b1) begin
					next_st.chan[i].retry = '0;
				end else begin
					next_st.chan[i].retry = st.chan[i].retry + 1'b1;
				end
			end else begin
				next_st.chan[i].retry = '0;
			end

			// Short detection after mask and deglitch
			short_set = 1'b0;
			if (st.gate[i] & mask_done & drain & ~batt) begin
				if (st.chan[i].dgl == pdc_pkg::DGL_CYC - 1'b1) begin
					short_set = 1'b1;
					next_st.chan[i].dgl = '0;
				end else begin
					next_st.chan[i].dgl = st.chan[i].dgl + 1'b1;
				end
			end else begin
				next_st.chan[i].dgl = '0;
			end

			// Open-load check while off
			open_set = ~st.gate[i] & mask_done & ~drain & ~batt & ~st.chan[i].short_lat;

			// Clearing of the short latch
			short_clr = st.chan[i].cmd_prev & ~cmd;
			if (rmode & st.chan[i].short_lat & ~drain
				& (st.chan[i].retry == RETRY_PERIOD_CYC - 1'b1)) begin
				short_clr = 1'b1;
			end

			// Set wins over clear
			if (short_set) begin
				next_st.chan[i].short_lat = 1'b1;
			end else if (short_clr) begin
				next_st.chan[i].short_lat = 1'b0;
			end

			if (open_set) begin
				next_st.chan[i].open_lat = 1'b1;
			end else if (cs_rise) begin
				next_st.chan[i].open_lat = 1'b0;
			end

			// Gate drive
			if (st.chan[i].short_lat) begin
				gate_n = ~batt & cmd & rmode & in_pulse;
			end else begin
				gate_n = ~batt & cmd;
			end
			next_st.gate[i] = gate_n;

			// Restart mask on every gate change
			if (gate_n != st.gate[i]) begin
				next_st.chan[i].mask = pdc_pkg::MASK_CYC;
			end else if (!mask_done) begin
				next_st.chan[i].mask = st.chan[i].mask - 1'b1;
			end

			fault_word[i] = st.chan[i].short_lat | st.chan[i].open_lat;
			fault_event = fault_event | short_set | open_set;
			fault_pending = fault_pending | fault_word[i];
		end

		// ----------------------------------------
		// Fault flag
		// ----------------------------------------
		next_st.flag_level = 1'b0;
		if (fault_event | batt) begin
			next_st.flag = 1'b1;
		end else if (cs_fall & ~fault_pending) begin
			next_st.flag = 1'b0;
		end

		// ----------------------------------------
		// Serial frame
		// ----------------------------------------
		case (st.frame)
			pdc_pkg::FR_IDLE: begin
				if (cs_fall) begin
					next_st.shreg = fault_word;
					next_st.sout = fault_word[pdc_pkg::NUM_CH-1];
					next_st.sout_oe = 1'b1;
					next_st.frame = pdc_pkg::FR_SHIFT;
				end
			end
			pdc_pkg::FR_SHIFT: begin
				if (cs_rise) begin
					next_st.ctrl = st.shreg;
					next_st.sout_oe = 1'b0;
					next_st.frame = pdc_pkg::FR_IDLE;
				end else if (sclk_rise) begin
					next_st.shreg = {st.shreg[pdc_pkg::NUM_CH-2:0], st.sync2.serial_in};
				end else if (sclk_fall) begin
					next_st.sout = st.shreg[pdc_pkg::NUM_CH-1];
				end
			end
			default: begin
				next_st.frame = pdc_pkg::FR_IDLE;
				next_st.sout_oe = 1'b0;
			end
		endcase

		// ----------------------------------------
		// External reset pin
		// ----------------------------------------
		if (!st.sync2.ext_reset_n) begin
			next_st = '0;
			next_st.frame = pdc_pkg::FR_IDLE;
			next_st.sync1 = pins;
			next_st.sync2 = st.sync1;
			next_st.sync3 = st.sync2;
		end
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st <= '0;
			st.frame <= pdc_pkg::FR_IDLE;
		end else begin
			st <= next_st;
		end
	end

	assign gate_drive_out = st.gate;
	assign serial_out = st.sout;
	assign serial_out_oe = st.sout_oe;
	assign fault_flag_n = st.flag_level;
	assign fault_flag_n_oe = st.flag;

endmodule

// ==== verilog/pdc_pkg.sv ====
// Constants, carrier structs and state types of the four-channel predriver control block.
// Assumes a 50 MHz system clock; all pin-side inputs arrive asynchronous to it.
package pdc_pkg;

	localparam int NUM_CH = 4;
	localparam int CLK_MHZ = 50;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int FAULT_MASK_TIME_US = 60;
	localparam int SHORT_DEGLITCH_TIME_US = 8;
	localparam int RETRY_PERIOD_MS = 10;
	localparam int RETRY_PULSE_WIDTH_US = 68;

	localparam int MASK_W = 12;
	localparam int DGL_W = 9;
	localparam int RETRY_W = 20;

	localparam logic [MASK_W-1:0] MASK_CYC = MASK_W'(FAULT_MASK_TIME_US * CLK_MHZ);
	localparam logic [DGL_W-1:0] DGL_CYC = DGL_W'(SHORT_DEGLITCH_TIME_US * CLK_MHZ);
	localparam logic [RETRY_W-1:0] RETRY_PERIOD_CYC = RETRY_W'(RETRY_PERIOD_MS * 1000 * CLK_MHZ);
	localparam logic [RETRY_W-1:0] RETRY_PULSE_CYC = RETRY_W'(RETRY_PULSE_WIDTH_US * CLK_MHZ);

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [1:0] {
		FR_IDLE = 2'h1,
		FR_SHIFT = 2'h2
	} pdc_frame_e;

	typedef struct packed {
		logic cs_n;
		logic sclk;
		logic serial_in;
		logic ext_reset_n;
		logic battery_fault;
		logic retry_mode;
		logic [NUM_CH-1:0] parallel_gate_cmd;
		logic [NUM_CH-1:0] drain_sense_in;
	} pdc_pins_s;

	typedef struct packed {
		logic [MASK_W-1:0] mask;
		logic [DGL_W-1:0] dgl;
		logic [RETRY_W-1:0] retry;
		logic short_lat;
		logic open_lat;
		logic cmd_prev;
	} pdc_chan_s;

	typedef struct packed {
		pdc_pins_s sync1;
		pdc_pins_s sync2;
		pdc_pins_s sync3;
		pdc_frame_e frame;
		logic [NUM_CH-1:0] shreg;
		logic [NUM_CH-1:0] ctrl;
		logic [NUM_CH-1:0] gate;
		logic sout;
		logic sout_oe;
		logic flag;
		logic flag_level;
		pdc_chan_s [NUM_CH-1:0] chan;
	} pdc_state_s;

endpackage

// ==== bench/pdc_mcu_model.sv ====
// Controller model: frames serial transfers on chip select, link clock and data.
// Assumes clk is the bench clock; the link clock is high for four clk cycles and low for ten.
`timescale 1ns/100ps
module pdc_mcu_model (
	input wire logic clk,
	input wire logic serial_out,
	output logic cs_n,
	output logic sclk,
	output logic serial_in
);
	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		serial_in = 1'b0;
	end
	task automatic xfer(input logic [7:0] d, input int n, output logic [7:0] r);
		r = 8'h00;
		@(posedge clk);
		cs_n <= 1'b0;
		repeat (8) @(posedge clk);
		for (int i = n - 1; i >= 0; i--) begin
			repeat (6) @(posedge clk);
			r = {r[6:0], serial_out};
			serial_in <= d[i];
			repeat (4) @(posedge clk);
			sclk <= 1'b1;
			repeat (4) @(posedge clk);
			sclk <= 1'b0;
		end
		repeat (4) @(posedge clk);
		cs_n <= 1'b1;
		serial_in <= ~serial_in;
		repeat (8) @(posedge clk);
	endtask
endmodule

// ==== bench/pdc_chk.sv ====
// Assertions on the predriver control pins.
// Assumes pins move on clk edges; battery input held low.
`timescale 1ns/100ps
module pdc_chk (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic ext_reset_n,
	input wire logic retry_mode,
	input wire logic [3:0] parallel_gate_cmd,
	input wire logic [3:0] gate_drive_out,
	input wire logic serial_out,
	input wire logic serial_out_oe,
	input wire logic fault_flag_n,
	input wire logic fault_flag_n_oe
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	property p_od;
		fault_flag_n == 1'b0;
	endproperty
	a_od: assert property (p_od) else $error("flag data high");
	property p_oe_on;
		$fell(cs_n) |-> ##[1:6] serial_out_oe;
	endproperty
	a_oe_on: assert property (p_oe_on) else $error("output not driven");
	property p_oe_off;
		$rose(cs_n) |-> ##[1:6] !serial_out_oe;
	endproperty
	a_oe_off: assert property (p_oe_off) else $error("output not floated");
	property p_idle;
		cs_n [*8] |-> !serial_out_oe;
	endproperty
	a_idle: assert property (p_idle) else $error("output driven idle");
	property p_sout;
		$rose(sclk) && !cs_n |-> $stable(serial_out) [*6];
	endproperty
	a_sout: assert property (p_sout) else $error("output moved on rise");
	property p_par;
		(parallel_gate_cmd[1] && ext_reset_n) [*8] |-> gate_drive_out[1];
	endproperty
	a_par: assert property (p_par) else $error("parallel ignored");
	property p_short;
		$fell(gate_drive_out[0]) && parallel_gate_cmd[0] && ext_reset_n && !retry_mode
			|-> ##[0:2] fault_flag_n_oe;
	endproperty
	a_short: assert property (p_short) else $error("shutdown without flag");
	property p_ext;
		!ext_reset_n [*6] |-> gate_drive_out == 4'h0 && !fault_flag_n_oe;
	endproperty
	a_ext: assert property (p_ext) else $error("external reset ignored");
	c_frame: cover property ($rose(cs_n));
	c_short: cover property ($fell(gate_drive_out[0]) && parallel_gate_cmd[0]);
	c_ext: cover property (!ext_reset_n [*6]);
endmodule

bind pdc_predriver_ctrl pdc_chk pdc_chk_i (.*);

// ==== bench/tb_pdc_predriver_ctrl.sv ====
// Self-checking bench for the predriver control block.
// Assumes the controller model frames transfers; drains track the inverted gates unless a fault is injected.
`timescale 1ns/100ps
module tb_pdc_predriver_ctrl;
	logic clk, rst_n, ext_reset_n, cs_n, sclk, serial_in, serial_out, serial_out_oe;
	logic fault_flag_n, fault_flag_n_oe, battery_fault, retry_mode;
	logic [3:0] parallel_gate_cmd, drain_sense_in, gate_drive_out, inj;
	logic [7:0] r;
	int err_count, tests_run;
	int cyc = 0;
	// Short retry period keeps the retry scenario inside the run budget
	pdc_predriver_ctrl #(
		.RETRY_PERIOD_CYC(20'h01F40)
	) pdc_predriver_ctrl_i (
		.clk(clk),
		.rst_n(rst_n),
		.cs_n(cs_n),
		.sclk(sclk),
		.serial_in(serial_in),
		.ext_reset_n(ext_reset_n),
		.battery_fault(battery_fault),
		.retry_mode(retry_mode),
		.parallel_gate_cmd(parallel_gate_cmd),
		.drain_sense_in(drain_sense_in),
		.gate_drive_out(gate_drive_out),
		.serial_out(serial_out),
		.serial_out_oe(serial_out_oe),
		.fault_flag_n(fault_flag_n),
		.fault_flag_n_oe(fault_flag_n_oe)
	);
	pdc_mcu_model pdc_mcu_model_i (
		.clk(clk),
		.serial_out(serial_out),
		.cs_n(cs_n),
		.sclk(sclk),
		.serial_in(serial_in)
	);
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	always @(posedge clk) begin
		drain_sense_in <= ~gate_drive_out ^ inj;
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			err_count++;
			finish_test();
		end
	end
	task automatic chk(input string s, input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] %s exp %h seen %h", s, exp, seen);
		end
	endtask
	task automatic finish_test;
		if (err_count == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic frame(input logic [7:0] d, input int n, input logic [3:0] g);
		pdc_mcu_model_i.xfer(d, n, r);
		chk("gate", gate_drive_out, g);
	endtask
	initial begin
		rst_n = 1'b0;
		ext_reset_n = 1'b1;
		battery_fault = 1'b0;
		retry_mode = 1'b0;
		parallel_gate_cmd = 4'h0;
		inj = 4'h0;
		err_count = 0;
		tests_run = 0;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		repeat (8) @(posedge clk);
		frame(8'h0A, 4, 4'hA);
		chk("word", r, 8'h00);
		chk("oe", serial_out_oe, 8'h00);
		frame(8'h53, 8, 4'h3);
		chk("cascade", r, 8'h05);
		frame(8'h02, 2, 4'h2);
		parallel_gate_cmd <= 4'h1;
		repeat (8) @(posedge clk);
		chk("or", gate_drive_out, 8'h03);
		frame(8'h00, 4, 4'h1);
		parallel_gate_cmd <= 4'h3;
		repeat (10) @(posedge clk);
		inj <= 4'h1;
		repeat (3600) @(posedge clk);
		chk("short", gate_drive_out, 8'h02);
		chk("flag", fault_flag_n_oe, 8'h01);
		inj <= 4'h0;
		frame(8'h00, 4, 4'h2);
		chk("fault", r, 8'h01);
		parallel_gate_cmd <= 4'h2;
		repeat (8) @(posedge clk);
		parallel_gate_cmd <= 4'h3;
		repeat (8) @(posedge clk);
		frame(8'h00, 4, 4'h3);
		chk("clear", fault_flag_n_oe, 8'h00);
		ext_reset_n <= 1'b0;
		repeat (8) @(posedge clk);
		chk("reset", gate_drive_out, 8'h00);
		// Retry variant: short on channel 0, periodic pulse, clear once short gone
		parallel_gate_cmd <= 4'h0;
		ext_reset_n <= 1'b1;
		repeat (8) @(posedge clk);
		retry_mode <= 1'b1;
		repeat (8) @(posedge clk);
		inj <= 4'h1;
		parallel_gate_cmd <= 4'h1;
		repeat (3500) @(posedge clk);
		chk("retry_off", gate_drive_out, 8'h00);
		chk("retry_flag", fault_flag_n_oe, 8'h01);
		inj <= 4'h0;
		repeat (5000) @(posedge clk);
		chk("retry_pulse", gate_drive_out, 8'h01);
		repeat (3500) @(posedge clk);
		chk("retry_clear", gate_drive_out, 8'h01);
		frame(8'h00, 4, 4'h1);
		chk("retry_word", r, 8'h00);
		chk("retry_flag_clr", fault_flag_n_oe, 8'h00);
		finish_test();
	end
endmodule
